/* fieldbus_master_status.sv */
`timescale 1ns/1ps
`include "fbm_defines.svh"

// What this block does
// (RULE_01) config-loaded flag is 1 while a configuration executes, else 0.
// (RULE_02) owned only while host connection count equals configured count.
// (RULE_03) address conflict sets conflict flag, enters back-off, bus silent.
// (RULE_04) back-off lasts 5 s; repeats while the conflicting master remains.
// (RULE_05) bus-fault flag is 1 while a network fault is detected.
// (RULE_06) slave-fault flag is 1 while any expected slave is not exchanging; code sets it only in clear or operate with the bus enabled.
// (RULE_07) offline state: offline indication set, no bus communication.
// (RULE_08) stop state: bus traffic but no process data; halted indication.
// (RULE_09) clear state: slaves polled, no output data sent; clear indication.
// (RULE_10) operate state: full process data exchange; operate indication set.
// (RULE_11) slave-emulation flag is 1 while acting as emulated slaves.
// (RULE_12) 16-bit signature of running configuration, updated on activation.
// (RULE_13) 128-bit online map, bit n for station n, stations 0 to 126.
// (RULE_14) exchange map bit is 1 only while station online and exchanging.
// (RULE_15) alarm map bit is 1 while the station holds an alarm to unload.
// (RULE_16) diag map bit is 1 while the station holds diagnostics to unload.
// (RULE_17) host commands bus state: 0 offline, 1 stop, 2 clear, 3 operate.
// (RULE_18) data exchange only with configured stations whose enable bit is 1.
// (RULE_19) exactly one of the four state indications is 1 at any time.
// (RULE_20) 8-bit node count equals the number of bits set in online map.

module fieldbus_master_status
#(
  parameter logic [`BACKOFF_CNT_W-1:0] BACKOFF_CYCLES =
    `BACKOFF_CNT_W'(`BACKOFF_CYCLES)
)
(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // configuration
  input  wire logic                        i_config_loaded,
  input  wire logic                        i_config_activate,
  input  wire logic [`SIGNATURE_W-1:0]     i_config_signature,
  input  wire logic [`CONN_COUNT_W-1:0]    i_cfg_conn_count,
  input  wire logic [`NODE_MAP_W-1:0]      i_node_configured,
  input  wire logic                        i_slave_mode,
  // host controller
  input  wire logic [`CONN_COUNT_W-1:0]    i_host_conn_count,
  input  wire logic [7:0]                  i_bus_state_command,
  input  wire logic [`NODE_MAP_W-1:0]      i_node_enable_map,
  // protocol engine events
  input  wire logic                        i_dup_detect,
  input  wire logic                        i_bus_fault,
  input  wire fbm_pkg::node_update_t       i_node_upd,
  // status toward the host
  output fbm_pkg::status_flags_t           o_status,
  output logic [`SIGNATURE_W-1:0]          o_config_signature,
  output logic [`NODE_COUNT_W-1:0]         o_online_node_count,
  output logic [`NODE_MAP_W-1:0]           o_node_online_map,
  output logic [`NODE_MAP_W-1:0]           o_node_exchange_map,
  output logic [`NODE_MAP_W-1:0]           o_node_alarm_map,
  output logic [`NODE_MAP_W-1:0]           o_node_diag_map,
  // control toward the protocol engine
  output logic                             o_bus_comm_en,
  output logic                             o_output_enable,
  output logic [`NODE_MAP_W-1:0]           o_exchange_allow
);

  fbm_pkg::master_state_t q;
  fbm_pkg::master_state_t d;
  logic                   timer_done;
  logic                   data_ok;
  logic [`NODE_MAP_W-1:0] expected;

  function automatic logic [`NODE_COUNT_W-1:0] ones_in
  (
    input logic [`NODE_MAP_W-1:0] m
  );
    logic [`NODE_COUNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < `NODE_MAP_W; i++)
      c = c + `NODE_COUNT_W'(m[i]);
    return c;
  endfunction

  backoff_timer
  #(
    .CYCLES (BACKOFF_CYCLES)
  )
  u_backoff
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (q.backoff_start),
    .o_busy  (),
    .o_done  (timer_done)
  );

  always_comb
  begin
    d               = q;
    d.backoff_start = 1'b0;
    data_ok         = 1'b0;
    expected        = '0;

    // (RULE_01) config loaded flag
    d.flags.config_loaded_flag = i_config_loaded;

    // (RULE_02) ownership by connection count
    d.flags.owned_flag = i_config_loaded
                         && (i_cfg_conn_count != '0)
                         && (i_host_conn_count == i_cfg_conn_count);

    // (RULE_12) signature follows activation
    if (i_config_activate)
      d.signature = i_config_signature;

    // (RULE_03) conflict detection enters back-off
    if (i_dup_detect && !q.flags.station_address_conflict)
    begin
      d.flags.station_address_conflict = 1'b1;
      d.backoff_start                  = 1'b1;
    end
    // (RULE_04) re-enter back-off while conflict remains
    else if (q.flags.station_address_conflict && timer_done)
    begin
      if (i_dup_detect)
        d.backoff_start = 1'b1;
      else
        d.flags.station_address_conflict = 1'b0;
    end

    // (RULE_17) host command selects bus state
    if (!i_config_loaded)
      d.state = fbm_pkg::ST_OFFLINE;
    else
    begin
      unique case (i_bus_state_command)
        `CMD_OFFLINE: d.state = fbm_pkg::ST_OFFLINE;
        `CMD_HALT:    d.state = fbm_pkg::ST_HALTED;
        `CMD_CLEAR:   d.state = fbm_pkg::ST_CLEAR;
        `CMD_OPERATE: d.state = fbm_pkg::ST_OPERATE;
        default:      d.state = q.state;
      endcase
    end

    // (RULE_19) one-hot state indications
    d.flags.state_offline_ind = (d.state == fbm_pkg::ST_OFFLINE);
    d.flags.state_halted_ind  = (d.state == fbm_pkg::ST_HALTED);
    d.flags.state_clear_ind   = (d.state == fbm_pkg::ST_CLEAR);
    d.flags.state_operate_ind = (d.state == fbm_pkg::ST_OPERATE);

    // (RULE_07) offline or back-off keeps the bus silent
    d.comm_en = !d.flags.state_offline_ind
                && !d.flags.station_address_conflict;
    // (RULE_09) outputs reach slaves only in operate
    d.out_en  = d.comm_en && d.flags.state_operate_ind;

    // (RULE_08) no process data while halted
    data_ok = d.comm_en
              && (d.flags.state_clear_ind || d.flags.state_operate_ind);
    // (RULE_18) configured and enabled stations only
    expected = i_node_configured & i_node_enable_map & `NODE_VALID_MASK;
    // (RULE_10) exchange with every expected slave
    d.allow  = data_ok ? expected : '0;

    // (RULE_13) per-station updates, station 127 ignored
    if (i_node_upd.valid && (i_node_upd.addr <= `NODE_ADDR_MAX))
    begin
      d.online[i_node_upd.addr] = i_node_upd.online;
      d.exch[i_node_upd.addr]   = i_node_upd.online
                                  && i_node_upd.exchanging;
      // (RULE_15) alarm pending per station
      d.alarm[i_node_upd.addr]  = i_node_upd.online && i_node_upd.alarm;
      // (RULE_16) diagnostics pending per station
      d.diag[i_node_upd.addr]   = i_node_upd.online && i_node_upd.diag;
    end
    if (!d.comm_en)
    begin
      d.online = '0;
      d.alarm  = '0;
      d.diag   = '0;
    end
    d.online = d.online & `NODE_VALID_MASK;
    // (RULE_14) exchange implies online and permitted
    d.exch   = d.exch & d.online & d.allow;

    // (RULE_20) node count from the new online map
    d.count = ones_in(d.online);

    // (RULE_05) network fault level
    d.flags.bus_fault_flag = i_bus_fault;
    // (RULE_06) an expected slave not exchanging
    d.flags.slave_comm_fault_flag = data_ok && |(expected & ~d.exch);
    // (RULE_11) slave emulation mode
    d.flags.slave_emulation_flag = i_slave_mode && i_config_loaded;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      q                         <= '0;
      q.state                   <= fbm_pkg::ST_OFFLINE;
      q.flags.state_offline_ind <= 1'b1;
      q.signature               <= `SIGNATURE_RST;
    end
    else
      q <= d;
  end

  assign o_status            = q.flags;
  assign o_config_signature  = q.signature;
  assign o_online_node_count = q.count;
  assign o_node_online_map   = q.online;
  assign o_node_exchange_map = q.exch;
  assign o_node_alarm_map    = q.alarm;
  assign o_node_diag_map     = q.diag;
  assign o_bus_comm_en       = q.comm_en;
  assign o_output_enable     = q.out_en;
  assign o_exchange_allow    = q.allow;

  state_onehot_a: assert property ( // RULE_19
    @(posedge i_clk) disable iff (i_rst)
    $onehot({o_status.state_offline_ind, o_status.state_halted_ind,
             o_status.state_clear_ind, o_status.state_operate_ind}))
    else $error("state indications not one-hot");

  node_count_a: assert property ( // RULE_20
    @(posedge i_clk) disable iff (i_rst)
    o_online_node_count == `NODE_COUNT_W'($countones(o_node_online_map)))
    else $error("node count differs from online map");

  offline_silent_a: assert property ( // RULE_07
    @(posedge i_clk) disable iff (i_rst)
    o_status.state_offline_ind |-> !o_bus_comm_en && o_exchange_allow == '0)
    else $error("bus active while offline");

  halted_no_data_a: assert property ( // RULE_08
    @(posedge i_clk) disable iff (i_rst)
    o_status.state_halted_ind |-> o_exchange_allow == '0
      && o_node_exchange_map == '0)
    else $error("data exchange while halted");

  clear_no_output_a: assert property ( // RULE_09
    @(posedge i_clk) disable iff (i_rst)
    o_status.state_clear_ind |-> !o_output_enable)
    else $error("outputs sent in clear state");

  exchange_online_a: assert property ( // RULE_14
    @(posedge i_clk) disable iff (i_rst)
    (o_node_exchange_map & ~o_node_online_map) == '0)
    else $error("exchanging station not online");

  conflict_entry_a: assert property ( // RULE_03
    @(posedge i_clk) disable iff (i_rst)
    !i_rst && i_dup_detect && !o_status.station_address_conflict |=>
      o_status.station_address_conflict && !o_bus_comm_en)
    else $error("conflict did not silence the bus");

  owned_match_a: assert property ( // RULE_02
    @(posedge i_clk) disable iff (i_rst)
    o_status.owned_flag |->
      $past(i_host_conn_count) == $past(i_cfg_conn_count))
    else $error("owned without matching connections");

  operate_cmd_a: assert property ( // RULE_10
    @(posedge i_clk) disable iff (i_rst)
    !i_rst && i_config_loaded && i_bus_state_command == `CMD_OPERATE |=>
      o_status.state_operate_ind)
    else $error("operate command not reflected");

  enable_gate_a: assert property ( // RULE_18
    @(posedge i_clk) disable iff (i_rst)
    (o_exchange_allow & ~$past(i_node_enable_map)) == '0)
    else $error("exchange allowed for disabled node");

  fault_follow_a: assert property ( // RULE_05
    @(posedge i_clk) disable iff (i_rst)
    !i_rst |=> o_status.bus_fault_flag == $past(i_bus_fault))
    else $error("bus fault flag does not follow fault");

  config_flag_a: assert property ( // RULE_01
    @(posedge i_clk) disable iff (i_rst)
    !i_rst |=> o_status.config_loaded_flag == $past(i_config_loaded))
    else $error("config flag does not follow load state");

  unloaded_offline_a: assert property ( // RULE_17
    @(posedge i_clk) disable iff (i_rst)
    !i_rst && !i_config_loaded |=>
      o_status.state_offline_ind && o_node_online_map == '0)
    else $error("no configuration but bus not offline");

  slave_fault_a: assert property ( // RULE_06
    @(posedge i_clk) disable iff (i_rst)
    o_status.slave_comm_fault_flag
      == |(o_exchange_allow & ~o_node_exchange_map))
    else $error("slave fault flag disagrees with exchange map");

  emulation_flag_a: assert property ( // RULE_11
    @(posedge i_clk) disable iff (i_rst)
    !i_rst |=> o_status.slave_emulation_flag
      == $past(i_slave_mode && i_config_loaded))
    else $error("slave emulation flag wrong");

  signature_load_a: assert property ( // RULE_12
    @(posedge i_clk) disable iff (i_rst)
    !i_rst && i_config_activate |=>
      o_config_signature == $past(i_config_signature))
    else $error("signature not taken on activation");

  conflict_hold_a: assert property ( // RULE_04
    @(posedge i_clk) disable iff (i_rst)
    o_status.station_address_conflict && i_dup_detect |=>
      o_status.station_address_conflict)
    else $error("conflict cleared while duplicate still seen");

endmodule

/* fbm_defines.svh */
`ifndef FBM_DEFINES_SVH
`define FBM_DEFINES_SVH

// node maps and station addressing
`define NODE_MAP_W       128
`define NODE_ADDR_W      7
`define NODE_ADDR_MAX    7'h7e
`define NODE_VALID_MASK  {1'b0, {127{1'b1}}}
`define NODE_COUNT_W     8

// bus state command encodings
`define CMD_OFFLINE      8'h00
`define CMD_HALT         8'h01
`define CMD_CLEAR        8'h02
`define CMD_OPERATE      8'h03

// signature width and reset value, connection count width
`define SIGNATURE_W      16
`define SIGNATURE_RST    16'h0000
`define CONN_COUNT_W     8

// timing
`define CLK_PERIOD_NS    10
`define BACKOFF_TIME_S   5
`define BACKOFF_CYCLES   (`BACKOFF_TIME_S * 64'd1000000000 / `CLK_PERIOD_NS)
`define BACKOFF_CNT_W    32

`endif

/* fbm_pkg.sv */
`include "fbm_defines.svh"

package fbm_pkg;

  typedef enum logic [1:0]
  {
    ST_OFFLINE,
    ST_HALTED,
    ST_CLEAR,
    ST_OPERATE
  } bus_state_t;

  typedef struct packed
  {
    logic                     valid;
    logic [`NODE_ADDR_W-1:0]  addr;
    logic                     online;
    logic                     exchanging;
    logic                     alarm;
    logic                     diag;
  } node_update_t;

  typedef struct packed
  {
    logic config_loaded_flag;
    logic owned_flag;
    logic station_address_conflict;
    logic bus_fault_flag;
    logic slave_comm_fault_flag;
    logic state_offline_ind;
    logic state_halted_ind;
    logic state_clear_ind;
    logic state_operate_ind;
    logic slave_emulation_flag;
  } status_flags_t;

  typedef struct packed
  {
    bus_state_t                state;
    status_flags_t             flags;
    logic [`SIGNATURE_W-1:0]   signature;
    logic [`NODE_COUNT_W-1:0]  count;
    logic [`NODE_MAP_W-1:0]    online;
    logic [`NODE_MAP_W-1:0]    exch;
    logic [`NODE_MAP_W-1:0]    alarm;
    logic [`NODE_MAP_W-1:0]    diag;
    logic [`NODE_MAP_W-1:0]    allow;
    logic                      comm_en;
    logic                      out_en;
    logic                      backoff_start;
  } master_state_t;

  typedef struct packed
  {
    logic [`BACKOFF_CNT_W-1:0] cnt;
    logic                      busy;
    logic                      done;
  } timer_state_t;

endpackage

/* backoff_timer.sv */
`timescale 1ns/1ps
`include "fbm_defines.svh"

module backoff_timer
#(
  parameter logic [`BACKOFF_CNT_W-1:0] CYCLES =
    `BACKOFF_CNT_W'(`BACKOFF_CYCLES)
)
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_start,
  // status
  output logic      o_busy,
  output logic      o_done
);

  fbm_pkg::timer_state_t q;
  fbm_pkg::timer_state_t d;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (i_start)
    begin
      d.cnt  = CYCLES - `BACKOFF_CNT_W'(1);
      d.busy = 1'b1;
    end
    else if (q.busy)
    begin
      if (q.cnt == '0)
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt - `BACKOFF_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_busy = q.busy;
  assign o_done = q.done;

  // each busy cycle counts down by one, then ends with a done pulse
  timer_length_a: assert property (@(posedge i_clk) disable iff (i_rst)
    q.busy && !i_start |=>
      ($past(q.cnt) == '0)
        ? (q.done && !q.busy)
        : (q.busy && q.cnt == $past(q.cnt) - `BACKOFF_CNT_W'(1)))
    else $error("back-off timer skipped a count");

endmodule

/* host_model.sv */
`timescale 1ns/1ps

module host_model
(
  // clock
  input  wire logic         i_clk,
  // requests from the bench
  input  wire logic [7:0]   i_mode_req,
  input  wire logic [7:0]   i_conn_req,
  input  wire logic [127:0] i_enable_req,
  // cyclic output image toward the device
  output logic [7:0]        o_bus_state_command,
  output logic [7:0]        o_host_conn_count,
  output logic [127:0]      o_node_enable_map
);
  // image refreshed once a cycle, so the device sees it one cycle late
  always_ff @(posedge i_clk)
  begin
    o_bus_state_command <= i_mode_req;
    o_host_conn_count   <= i_conn_req;
    // enable bits, none above station 126
    o_node_enable_map   <= {1'b0, i_enable_req[126:0]};
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "fbm_defines.svh"

module tb_top;
  localparam int BO = 20;

  typedef struct packed
  {
    logic [7:0]  cmd;
    logic [7:0]  conns;
    logic        loaded;
    logic        slave;
    logic        fault;
    logic [11:0] exp;
  } row_t;

  logic                   i_clk = 1'b0;
  logic                   i_rst = 1'b1;
  logic                   loaded = 1'b0;
  logic                   activate = 1'b0;
  logic [15:0]            sig = 16'h0000;
  logic [127:0]           configured = 128'h0;
  logic                   slave = 1'b0;
  logic [7:0]             mode_req = 8'h00;
  logic [7:0]             conn_req = 8'h00;
  logic [7:0]             cfg_conns = 8'h02;
  logic [127:0]           enable_req = 128'h0;
  logic                   dup = 1'b0;
  logic                   fault = 1'b0;
  fbm_pkg::node_update_t  upd = '0;
  logic [7:0]             cmd_w;
  logic [7:0]             conn_w;
  logic [127:0]           enable_w;
  fbm_pkg::status_flags_t status;
  logic [15:0]            sig_o;
  logic [7:0]             count;
  logic [127:0]           online, exch, alarm, diag, allow;
  logic                   comm_en, out_en;
  int                     fails = 0, num_checks = 0, cycles = 0;
  row_t                   rows [6];

  always #5 i_clk = ~i_clk;

  host_model host (.i_clk(i_clk), .i_mode_req(mode_req),
    .i_conn_req(conn_req), .i_enable_req(enable_req),
    .o_bus_state_command(cmd_w), .o_host_conn_count(conn_w),
    .o_node_enable_map(enable_w));

  fieldbus_master_status #(.BACKOFF_CYCLES(BO)) dut (.i_clk(i_clk),
    .i_rst(i_rst), .i_config_loaded(loaded), .i_config_activate(activate),
    .i_config_signature(sig), .i_cfg_conn_count(cfg_conns),
    .i_node_configured(configured), .i_slave_mode(slave),
    .i_host_conn_count(conn_w), .i_bus_state_command(cmd_w),
    .i_node_enable_map(enable_w), .i_dup_detect(dup), .i_bus_fault(fault),
    .i_node_upd(upd), .o_status(status), .o_config_signature(sig_o),
    .o_online_node_count(count), .o_node_online_map(online),
    .o_node_exchange_map(exch), .o_node_alarm_map(alarm),
    .o_node_diag_map(diag), .o_bus_comm_en(comm_en),
    .o_output_enable(out_en), .o_exchange_allow(allow));

  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one-cycle update pulse; fields are online, exchanging, alarm, diag
  task automatic node(input logic [6:0] a, input logic [3:0] f);
    @(posedge i_clk);
    upd <= {1'b1, a, f};
    @(posedge i_clk);
    upd.valid <= 1'b0;
    #1;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    logic [11:0] g, e;
    int n;
    // expected: flags MSB first, then bus comm enable, output enable
    rows[0] = '{8'h03, 8'h02, 1'b1, 1'b0, 1'b0, 12'b1100_1000_1011};
    rows[1] = '{8'h01, 8'h01, 1'b1, 1'b1, 1'b1, 12'b1001_0010_0110};
    rows[2] = '{8'h02, 8'h02, 1'b1, 1'b0, 1'b0, 12'b1100_1001_0010};
    rows[3] = '{8'h09, 8'h02, 1'b1, 1'b0, 1'b0, 12'b1100_1001_0010};
    rows[4] = '{8'h00, 8'h03, 1'b1, 1'b0, 1'b1, 12'b1001_0100_0000};
    rows[5] = '{8'h03, 8'h02, 1'b0, 1'b1, 1'b0, 12'b0000_0100_0000};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    check("status_rst", status, 10'b00000_10000);
    check("sig_rst", sig_o, 16'h0000);
    @(posedge i_clk);
    configured <= 128'h20;
    enable_req <= (128'h3 << 126) | 128'h20;
    foreach (rows[i])
    begin
      @(posedge i_clk);
      mode_req <= rows[i].cmd;
      conn_req <= rows[i].conns;
      loaded <= rows[i].loaded;
      slave <= rows[i].slave;
      fault <= rows[i].fault;
      repeat (3) @(posedge i_clk);
      #1;
      g = {status, comm_en, out_en};
      e = rows[i].exp;
      check("cfg", g[11:10], e[11:10]);
      check("faults", g[9:7], e[9:7]);
      check("state", g[6:3], e[6:3]);
      check("emul", g[2], e[2]);
      check("enables", g[1:0], e[1:0]);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      sig <= k ? 16'hc3e1 : 16'h5a3c;
      activate <= 1'b1;
      @(posedge i_clk);
      activate <= 1'b0;
      sig <= 16'hffff;
      #1;
      check("sig", sig_o, k ? 16'hc3e1 : 16'h5a3c);
    end
    @(posedge i_clk);
    loaded <= 1'b1;
    slave <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    check("sig_hold", sig_o, 16'hc3e1);
    node(7'h05, 4'b1111);
    check("online", online, 128'h20);
    check("exch", exch, 128'h20);
    check("alarm", alarm, 128'h20);
    check("diag", diag, 128'h20);
    check("count1", count, 8'h01);
    check("slvf0", status.slave_comm_fault_flag, 1'b0);
    node(7'h7e, 4'b1100);
    check("exch_126", exch[126], 1'b0);
    check("allow", allow, 128'h20);
    check("count2", count, 8'h02);
    node(7'h7f, 4'b1111);
    check("online_127", online[127], 1'b0);
    check("count_127", count, 8'h02);
    node(7'h05, 4'b1000);
    check("exch_off", exch[5], 1'b0);
    check("alarm_clr", alarm, 128'h0);
    check("diag_clr", diag, 128'h0);
    check("slvf1", status.slave_comm_fault_flag, 1'b1);
    @(posedge i_clk);
    dup <= 1'b1;
    @(posedge i_clk);
    dup <= 1'b0;
    #1;
    check("conflict", status.station_address_conflict, 1'b1);
    check("comm_off", comm_en, 1'b0);
    check("cnt_clr", count, 8'h00);
    n = 1;
    while (status.station_address_conflict === 1'b1 && n < 4 * BO)
    begin
      @(posedge i_clk);
      n++;
      #1;
    end
    check("backoff_len", n >= BO && n <= BO + 4, 1'b1);
    @(posedge i_clk);
    #1;
    check("comm_back", comm_en, 1'b1);
    @(posedge i_clk);
    dup <= 1'b1;
    repeat (3 * BO) @(posedge i_clk);
    dup <= 1'b0;
    #1;
    check("reenter", status.station_address_conflict, 1'b1);
    n = 0;
    while (status.station_address_conflict === 1'b1 && n < 4 * BO)
    begin
      @(posedge i_clk);
      n++;
      #1;
    end
    check("release", status.station_address_conflict, 1'b0);
    // owned needs a nonzero configured count matched by the host
    @(posedge i_clk);
    cfg_conns <= 8'h00;
    conn_req <= 8'h00;
    repeat (3) @(posedge i_clk);
    #1;
    check("owned_zero", status.owned_flag, 1'b0);
    @(posedge i_clk);
    cfg_conns <= 8'h03;
    conn_req <= 8'h03;
    repeat (3) @(posedge i_clk);
    #1;
    check("owned_three", status.owned_flag, 1'b1);
    // reset in mid-run returns to offline, then operate resumes
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    check("status_rst2", status, 10'b00000_10000);
    check("maps_rst2", online | exch | allow, 128'h0);
    check("sig_rst2", sig_o, 16'h0000);
    @(posedge i_clk);
    #1;
    g = {status, comm_en, out_en};
    check("operate_rst2", g, 12'b1100_1000_1011);
    conclude();
  end
endmodule
